// file: clock_fanout_pkg.sv
package clock_fanout_pkg;

  // ==========================================================
  // Sizes and reset values
  // ==========================================================
  localparam int   FANOUT_PAIRS   = 5;
  localparam logic GATE_RESET_VAL = 1'b0;
  localparam logic SEL_PREV_RESET = 1'b0;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [1:0]
  {
    GATE_OFF = 2'b01,
    GATE_ON  = 2'b10
  } gate_state_t;

  typedef struct packed
  {
    logic [FANOUT_PAIRS-1:0] true_out;
    logic [FANOUT_PAIRS-1:0] comp_out;
  } out_pair_t;

endpackage : clock_fanout_pkg

// file: diff_input_resolve.sv
`timescale 1ns/10ps
module diff_input_resolve
(
  input  wire logic diff_p,
  input  wire logic diff_n,
  input  wire logic p_open,
  input  wire logic n_open,
  input  wire logic p_is_bias,
  input  wire logic n_is_bias,
  output logic      level
);

  // ==========================================================
  // Resolve the differential input to one logic level
  // ==========================================================
  wire both_open = p_open & n_open;
  wire p_level   = p_open ? 1'b0 : diff_p;
  wire n_level   = n_open ? 1'b1 : diff_n;
  wire se_true   = n_is_bias & ~p_is_bias;
  wire se_inv    = p_is_bias & ~n_is_bias;

  // Open pins bias to differential low
  assign level = both_open ? 1'b0 :                                  // [R8]
                 se_true   ? p_level :                                // [R9]
                 se_inv    ? ~n_level :                               // [R9]
                 (p_level & ~n_level);

endmodule : diff_input_resolve

// file: clock_select_fanout_sync_enable.sv
`timescale 1ns/10ps
// How it works
// R1: Low input_choice picks the differential clock, high the single one.
// R2: The chosen signal drives all five pairs, true and inverted copies.
// R3: The active-low gate passes a flip-flop clocked by clk and loaded on falling edges of the chosen clock.
// R4: Gate low: outputs start at the next falling edge of the chosen clock.
// R5: Gate high: outputs go low at the next falling edge and stay low.
// R6: Enable changes only while the chosen clock is low; no pulse is cut.
// R7: After power-up the source holds the gate low and toggles the clock.
// R8: Both differential pins open read as a steady differential low.
// R9: With bias on one half, the other half drives outputs true or inverted.
// R10: Disabled: true low, complement high; the selector is combinational.
module clock_select_fanout_sync_enable
(
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         diff_clock_p,
  input  wire logic                         diff_clock_n,
  input  wire logic                         diff_p_open,
  input  wire logic                         diff_n_open,
  input  wire logic                         diff_p_bias,
  input  wire logic                         diff_n_bias,
  input  wire logic                         single_clock_in,
  input  wire logic                         input_choice,
  input  wire logic                         output_gate_n,
  output clock_fanout_pkg::out_pair_t       out_pair
);

  // ==========================================================
  // Input selection
  // ==========================================================
  // The chosen input is sampled on clk, not used as a clock; its
  // falling edge is found by comparing the last sample with the current value.
  logic                          diff_level;
  logic                          chosen_reg;
  logic                          chosen_next;
  logic                          gate_en_reg;
  logic                          gate_en_next;
  clock_fanout_pkg::gate_state_t state_reg;
  clock_fanout_pkg::gate_state_t state_next;
  clock_fanout_pkg::out_pair_t   out_reg;
  clock_fanout_pkg::out_pair_t   out_next;

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic clock_fanout_pkg::out_pair_t pair_from
  (
    input logic level
  );
    clock_fanout_pkg::out_pair_t result;
    result.true_out = {clock_fanout_pkg::FANOUT_PAIRS{level}};
    result.comp_out = {clock_fanout_pkg::FANOUT_PAIRS{~level}};
    return result;
  endfunction : pair_from

  diff_input_resolve u_diff_input_resolve
  (
    .diff_p    (diff_clock_p),
    .diff_n    (diff_clock_n),
    .p_open    (diff_p_open),
    .n_open    (diff_n_open),
    .p_is_bias (diff_p_bias),
    .n_is_bias (diff_n_bias),
    .level     (diff_level)
  );

  // No resynchronisation of input_choice; a switch mid-pulse may glitch
  assign chosen_next = input_choice ? single_clock_in  // [R1]
                                    : diff_level;      // [R10]

  // ==========================================================
  // Synchronous enable
  // ==========================================================
  wire fall_edge = chosen_reg & ~chosen_next;

  // Gate sampled only on a falling edge, when the clock is already low
  assign gate_en_next = fall_edge ? ~output_gate_n   // [R3] [R4] [R5]
                                  : gate_en_reg;     // [R6]
  assign state_next   = gate_en_next ? clock_fanout_pkg::GATE_ON
                                     : clock_fanout_pkg::GATE_OFF;

  logic drive;
  always_comb
  begin
    drive = 1'b0;
    case (state_next)
      clock_fanout_pkg::GATE_ON:  drive = chosen_next;
      clock_fanout_pkg::GATE_OFF: drive = 1'b0;                     // [R10]
      default:                    drive = 1'b0;
    endcase
  end

  // Outputs stay disabled until one falling edge with gate low
  assign out_next = pair_from(drive); // [R2] [R7]

  // ==========================================================
  // Input history
  // ==========================================================
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      chosen_reg <= clock_fanout_pkg::SEL_PREV_RESET;
    end
    else
    begin
      chosen_reg <= chosen_next;
    end
  end

  // ==========================================================
  // Enable state
  // ==========================================================
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      gate_en_reg <= clock_fanout_pkg::GATE_RESET_VAL;
      state_reg   <= clock_fanout_pkg::GATE_OFF;
    end
    else
    begin
      gate_en_reg <= gate_en_next;
      state_reg   <= state_next;
    end
  end

  // ==========================================================
  // Output register
  // ==========================================================
  // Registered so that all ten outputs switch on the same edge
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      out_reg <= pair_from(clock_fanout_pkg::GATE_RESET_VAL); // [R10]
    end
    else
    begin
      out_reg <= out_next;
    end
  end

  assign out_pair = out_reg;

  // ==========================================================
  // Checks
  // ==========================================================
  a_pairs_complement: assert property (@(posedge clk) // [R2]
    disable iff (!rst_n)
    out_pair.comp_out == ~out_pair.true_out)
    else $error("pair outputs not complementary");

  a_pairs_equal: assert property (@(posedge clk) // [R2]
    disable iff (!rst_n)
    out_pair == pair_from(out_pair.true_out[0]))
    else $error("pair outputs differ");

  a_disabled_low: assert property (@(posedge clk) // [R10]
    disable iff (!rst_n)
    state_reg == clock_fanout_pkg::GATE_OFF |-> out_pair.true_out == '0)
    else $error("disabled output not low");

  a_disabled_comp_high: assert property (@(posedge clk) // [R10]
    disable iff (!rst_n)
    state_reg == clock_fanout_pkg::GATE_OFF |-> out_pair.comp_out == '1)
    else $error("disabled complement not high");

  a_enabled_follows: assert property (@(posedge clk) // [R1]
    disable iff (!rst_n)
    state_reg == clock_fanout_pkg::GATE_ON && !$past(input_choice)
    |-> out_pair.true_out[0] == $past(diff_level))
    else $error("enabled output not following differential input");

  a_single_follows: assert property (@(posedge clk) // [R1]
    disable iff (!rst_n)
    state_reg == clock_fanout_pkg::GATE_ON && $past(input_choice)
    |-> out_pair.true_out[0] == $past(single_clock_in))
    else $error("enabled output not following single input");

  a_enable_on_fall: assert property (@(posedge clk) // [R4]
    disable iff (!rst_n)
    $rose(gate_en_reg) |-> $fell(chosen_reg) && !$past(output_gate_n))
    else $error("enable not on falling edge");

  a_disable_on_fall: assert property (@(posedge clk) // [R5]
    disable iff (!rst_n)
    $fell(gate_en_reg) |-> $fell(chosen_reg) && $past(output_gate_n))
    else $error("disable not on falling edge");

  a_no_truncation: assert property (@(posedge clk) // [R6]
    disable iff (!rst_n)
    $changed(gate_en_reg) |-> !chosen_reg)
    else $error("gate changed while clock high");

  a_gate_held: assert property (@(posedge clk) // [R3]
    disable iff (!rst_n)
    !$fell(chosen_reg) |-> $stable(gate_en_reg))
    else $error("gate changed without falling edge");

  a_off_until_fall: assert property (@(posedge clk) // [R7]
    disable iff (!rst_n)
    state_reg == clock_fanout_pkg::GATE_OFF ##1 !$fell(chosen_reg)
    |-> state_reg == clock_fanout_pkg::GATE_OFF)
    else $error("outputs enabled without falling edge");

  a_reset_quiet: assert property (@(posedge clk) // [R7]
    $rose(rst_n) |-> state_reg == clock_fanout_pkg::GATE_OFF
    && out_pair == pair_from(clock_fanout_pkg::GATE_RESET_VAL))
    else $error("outputs not disabled after reset");

  a_open_low: assert property (@(posedge clk) // [R8]
    disable iff (!rst_n)
    diff_p_open && diff_n_open |-> !diff_level)
    else $error("open differential input not low");

  a_bias_true: assert property (@(posedge clk) // [R9]
    disable iff (!rst_n)
    diff_n_bias && !diff_p_bias && !diff_p_open
    |-> diff_level == diff_clock_p)
    else $error("biased input not following true half");

  a_bias_inv: assert property (@(posedge clk) // [R9]
    disable iff (!rst_n)
    diff_p_bias && !diff_n_bias && !diff_n_open
    |-> diff_level == !diff_clock_n)
    else $error("biased input not inverting other half");

endmodule : clock_select_fanout_sync_enable

// file: clock_source.sv
`timescale 1ns/10ps
// ==========================================================
// Slow clock source; stands still while not running
// ==========================================================
module clock_source
(
  input  wire logic clk,
  input  wire logic run,
  output logic      level
);
  logic [1:0] cnt_reg;
  always_ff @(posedge clk)
  begin
    cnt_reg <= run ? cnt_reg + 2'h1 : 2'h0;
    level   <= run & cnt_reg[1];
  end
endmodule : clock_source

// file: test_clock_select_fanout_sync_enable.sv
`timescale 1ns/10ps
module test_clock_select_fanout_sync_enable;
  logic clk = 1'b0, rst_n = 1'b0, run = 1'b0, sclk;
  logic dp = 1'b0, dn = 1'b0, po = 1'b0, no = 1'b0, pb = 1'b0, nb = 1'b0;
  logic sel = 1'b1, gate_n = 1'b0;
  logic en_reg = 1'b0, prev_reg = 1'b0, exp_reg = 1'b0;
  logic pv, nv, res, cho, fall;
  int   n_fail = 0, n_compared = 0;
  clock_fanout_pkg::out_pair_t out_pair;
  // ==========================================================
  // Reference; open halves read as p low, n high
  // ==========================================================
  always #5 clk = ~clk;
  assign pv   = po ? 1'b0 : dp;
  assign nv   = no ? 1'b1 : dn;
  assign res  = nb ? pv : (pb ? ~nv : pv & ~nv);
  assign cho  = sel ? sclk : res;
  assign fall = prev_reg & ~cho;
  always @(posedge clk)
  begin
    en_reg   <= rst_n & (fall ? ~gate_n : en_reg);
    prev_reg <= rst_n & cho;
    exp_reg  <= rst_n & cho & (fall ? ~gate_n : en_reg);
  end
  clock_source u_clock_source (.clk(clk), .run(run), .level(sclk));
  clock_select_fanout_sync_enable u_clock_select_fanout_sync_enable
  (
    .clk(clk), .rst_n(rst_n), .diff_clock_p(dp), .diff_clock_n(dn),
    .diff_p_open(po), .diff_n_open(no), .diff_p_bias(pb),
    .diff_n_bias(nb), .single_clock_in(sclk), .input_choice(sel),
    .output_gate_n(gate_n), .out_pair(out_pair)
  );
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error out_pair expected %h seen %h", exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n)
    begin
      #1 check(out_pair, {{5{exp_reg}}, {5{~exp_reg}}});
      @(posedge clk);
    end
  endtask : cyc
  // ==========================================================
  // Gate changes; short pulses between edges must be ignored
  // ==========================================================
  task automatic t_gate;
    run <= 1'b1;
    cyc(22);
    gate_n <= 1'b1;
    cyc(2);
    gate_n <= 1'b0;
    cyc(12);
    gate_n <= 1'b1;
    cyc(20);
    gate_n <= 1'b0;
    cyc(20);
    $display("t_gate done");
  endtask : t_gate
  // ==========================================================
  // Differential modes, open and bias cases
  // ==========================================================
  task automatic t_diff;
    logic [3:0] m;
    sel <= 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      m = i[3:0];
      if ((m[1] & m[0]) | ((m[1] | m[0]) & (m[3] | m[2])))
        continue;
      {po, no, pb, nb} <= m;
      for (int k = 0; k < 8; k++)
      begin
        {dp, dn} <= k[2:1];
        cyc(1);
      end
    end
    $display("t_diff done");
  endtask : t_diff
  task automatic close_out;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_gate;
    t_diff;
    close_out;
  end
  initial
  begin
    #20000;
    n_fail++;
    close_out;
  end
endmodule : test_clock_select_fanout_sync_enable
